// ===== core/cpu_act_cfg_pkg.sv
package cpu_act_cfg_pkg;
   // ****************************************
   // field layout
   // ****************************************
   localparam int PRESENT_BIT    = 31;
   localparam int XTC_LSB        = 21;
   localparam int XTC_W          = 8;
   localparam int TCS_BIT        = 19;
   localparam int SCS_BIT        = 18;
   localparam int DCS_BIT        = 17;
   localparam int ICS_BIT        = 16;
   localparam int MASTER_BIT     = 1;
   localparam int ACT_BIT        = 0;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] XTC_RST_CPU0   = 8'h00;
   localparam logic       MASTER_RST_CPU0 = 1'b1;
   localparam logic       ACT_RST_CPU0    = 1'b1;

   typedef struct packed {
      logic       wrEn;
      logic       crossCtx;
      logic       writerMaster;
      logic [31:0] data;
   } reg_write_t;

   typedef struct packed {
      logic       excLevelSet;
      logic       threadEnClear;
      logic       evpClear;
      logic [7:0] soleTc;
   } hw_event_t;
endpackage

// ===== core/cfg_field_latch.sv
`timescale 1ns/1ps
module cfg_field_latch #(
   parameter int        W        = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         arst_n,
   // load
   input  wire logic         ld,
   input  wire logic [W-1:0] d,
   // value
   output logic [W-1:0]      q
);
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q <= RST_VAL;
      end else if (ld) begin
         q <= d;
      end
   end
endmodule

// ===== core/virtual_cpu_activation_config.sv
`timescale 1ns/1ps
module virtual_cpu_activation_config
   import cpu_act_cfg_pkg::*;
#(
   parameter int         CPU_INDEX        = 0,
   parameter logic       HAS_SECOND_CFG   = 1'b1,
   parameter logic [3:0] CACHE_SHARED     = 4'h0,
   parameter logic       LOAD_ON_EVP_CLR  = 1'b0
) (
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       arst_n,
   // register access
   input  cpu_act_cfg_pkg::reg_write_t     wr,
   output logic [31:0]                     rdData,
   // hardware events
   input  cpu_act_cfg_pkg::hw_event_t      evt,
   input  wire logic                       excLevelNow,
   input  wire logic                       threadEnNow,
   input  wire logic                       enableVirtualCpus,
   // scheduling outputs
   output logic                            cpuRun,
   output logic                            exclusiveValid,
   output logic [7:0]                      exclusiveTc,
   output logic                            masterGrant
);
   import cpu_act_cfg_pkg::*;

   // ****************************************
   // storage
   // ****************************************
   localparam logic IS0 = (CPU_INDEX == 0);
   logic [7:0] xtc_ff;
   logic       master_ff;
   logic       act_ff;
   logic       excl_ff;
   logic       privWr;
   logic       xtcSwWr;
   logic       xtcHwLd;
   logic [7:0] nxt_xtc;
   logic       actRise;

   assign privWr  = wr.wrEn && wr.writerMaster;
   assign xtcSwWr = privWr && wr.crossCtx && !act_ff;
   assign xtcHwLd = evt.excLevelSet || evt.threadEnClear
                    || (LOAD_ON_EVP_CLR && evt.evpClear);
   assign nxt_xtc = xtcHwLd ? evt.soleTc : wr.data[XTC_LSB +: XTC_W];

   cfg_field_latch #(
      .W       (8),
      .RST_VAL (IS0 ? XTC_RST_CPU0 : 8'h00)
   ) u_xtc (
      .mclk   (mclk),
      .arst_n (arst_n),
      .ld     (xtcHwLd || xtcSwWr),
      .d      (nxt_xtc),
      .q      (xtc_ff)
   );

   // ****************************************
   // master and activation
   // ****************************************
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         master_ff <= IS0 ? MASTER_RST_CPU0 : 1'b0;
      end else if (privWr) begin
         master_ff <= wr.data[MASTER_BIT];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         act_ff <= IS0 ? ACT_RST_CPU0 : 1'b0;
      end else if (privWr) begin
         act_ff <= wr.data[ACT_BIT];
      end
   end

   // ****************************************
   // exclusive issue on activation
   // ****************************************
   assign actRise = privWr && wr.data[ACT_BIT];
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         excl_ff <= 1'b0;
      end else if (actRise) begin
         // a hardware load in the same cycle still wins
         excl_ff <= xtcHwLd || excLevelNow || !threadEnNow;
      end else if (xtcHwLd) begin
         excl_ff <= 1'b1;
      end else if (!excLevelNow && threadEnNow) begin
         excl_ff <= 1'b0;
      end
   end

   assign exclusiveValid = excl_ff;
   assign exclusiveTc    = xtc_ff;
   assign cpuRun         = act_ff && enableVirtualCpus;
   assign masterGrant    = master_ff;

   // ****************************************
   // read view
   // ****************************************
   always_comb begin
      rdData                        = 32'h0000_0000;
      rdData[PRESENT_BIT]           = HAS_SECOND_CFG;
      rdData[XTC_LSB +: XTC_W]      = xtc_ff;
      rdData[TCS_BIT]               = CACHE_SHARED[3];
      rdData[SCS_BIT]               = CACHE_SHARED[2];
      rdData[DCS_BIT]               = CACHE_SHARED[1];
      rdData[ICS_BIT]               = CACHE_SHARED[0];
      rdData[MASTER_BIT]            = master_ff;
      rdData[ACT_BIT]               = act_ff;
   end
endmodule

// ===== verification/cpu_act_cfg_properties.sv
`timescale 1ns/1ps
module cpu_act_cfg_props
   import cpu_act_cfg_pkg::*;
#(parameter logic P = 1'b1, parameter logic [3:0] C = 4'h0) (
   input wire logic                   mclk, arst_n,
   input cpu_act_cfg_pkg::reg_write_t wr,
   input cpu_act_cfg_pkg::hw_event_t  evt,
   input wire logic                   excLevelNow, threadEnNow, enableVirtualCpus,
   input wire logic [31:0]            rdData,
   input wire logic                   cpuRun, exclusiveValid, masterGrant,
   input wire logic [7:0]             exclusiveTc
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   wire hw = evt.excLevelSet | evt.threadEnClear;
   wire xw = wr.wrEn & wr.crossCtx & wr.writerMaster & ~rdData[0];
   a_present_flag: assert property (rdData[31] == P) else $error("presence flag wrong");
   a_cache_flags: assert property (rdData[19:16] == C) else $error("cache flags wrong");
   a_reserved_zero: assert property (rdData[30:29] == 2'h0 && !rdData[20] && rdData[15:2] == '0) else $error("rsvd");
   a_nonmaster_ignored: assert property (wr.wrEn && !wr.writerMaster && !hw |=> $stable(rdData)) else $error("wr");
   a_master_write: assert property (wr.wrEn && wr.writerMaster |=> rdData[1:0] == $past(wr.data[1:0])) else $error("mw");
   a_xtc_hw_load: assert property (hw |=> exclusiveValid && exclusiveTc == $past(evt.soleTc)) else $error("hw load");
   a_xtc_sw_write: assert property (xw && !hw |=> rdData[28:21] == $past(wr.data[28:21])) else $error("xtc write");
   a_xtc_held: assert property (!xw && !hw |=> $stable(rdData[28:21])) else $error("xtc changed");
   a_run_gate: assert property (cpuRun == (rdData[0] && enableVirtualCpus)) else $error("run gate");
   a_master_grant: assert property (masterGrant == rdData[1]) else $error("grant");
   a_act_exclusive: assert property (wr.wrEn && wr.writerMaster && wr.data[0]
      |=> exclusiveValid == ($past(excLevelNow) || !$past(threadEnNow) || $past(hw)))
      else $error("exclusive on activation wrong");
endmodule

// ===== verification/virtual_cpu_activation_config_test.sv
`timescale 1ns/1ps
module virtual_cpu_activation_config_test;
   import cpu_act_cfg_pkg::*;
   typedef struct packed { reg_write_t w; logic [31:0] e; } row_t;
   logic mclk, arst_n, excLevelNow, threadEnNow, enableVirtualCpus, cpuRun, exclusiveValid, masterGrant;
   reg_write_t wr;
   hw_event_t evt;
   logic [31:0] rdData;
   logic [7:0] exclusiveTc;
   int err_total, comparisons, cyc;
   // master, cross-context, non-master writes in turn
   row_t rows [5] = '{'{'{1'b1, 1'b1, 1'b1, 32'hffff_fffe}, 32'h8000_0002},
      '{'{1'b1, 1'b1, 1'b1, 32'h0aa0_0003}, 32'h8aa0_0003}, '{'{1'b1, 1'b1, 1'b0, 32'h0000_0000}, 32'h8aa0_0003},
      '{'{1'b1, 1'b0, 1'b1, 32'h0000_0001}, 32'h8aa0_0001}, '{'{1'b1, 1'b0, 1'b0, 32'h0000_0003}, 32'h8aa0_0001}};
   virtual_cpu_activation_config DUT (.mclk(mclk), .arst_n(arst_n), .wr(wr), .rdData(rdData), .evt(evt),
      .excLevelNow(excLevelNow), .threadEnNow(threadEnNow), .enableVirtualCpus(enableVirtualCpus),
      .cpuRun(cpuRun), .exclusiveValid(exclusiveValid), .exclusiveTc(exclusiveTc), .masterGrant(masterGrant));
   initial begin
      mclk = 0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 500) begin
         err_total++;
         end_sim();
      end
   end
   task chk(string n, logic [31:0] e, logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task end_sim();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task pulse(hw_event_t v);
      @(posedge mclk) evt <= v;
      @(posedge mclk) evt <= '0;
      #1;
   endtask
   initial begin
      arst_n = 0; wr = '0; evt = '0; excLevelNow = 0; threadEnNow = 1; enableVirtualCpus = 1;
      repeat (6) @(posedge mclk);
      arst_n <= 1;
      @(posedge mclk) #1;
      chk("rdData", 32'h8000_0003, rdData);
      chk("cpuRun", 32'h1, {31'h0, cpuRun});
      @(posedge mclk) enableVirtualCpus <= 0;
      #1 chk("cpuRun", 32'h0, {31'h0, cpuRun});
      @(posedge mclk) enableVirtualCpus <= 1;
      foreach (rows[i]) begin
         @(posedge mclk) wr <= rows[i].w;
         @(posedge mclk) wr <= '0;
         #1 chk("rdData", rows[i].e, rdData);
      end
      pulse('{1'b1, 1'b0, 1'b0, 8'h3c});
      chk("xtc", 32'h13c, {23'h0, exclusiveValid, rdData[28:21]});
      pulse('{1'b0, 1'b0, 1'b1, 8'h77});
      chk("xtc", 32'h3c, {24'h0, rdData[28:21]});
      pulse('{1'b0, 1'b1, 1'b0, 8'hff});
      chk("xtc", 32'hff, {24'h0, exclusiveTc});
      @(posedge mclk) begin
         excLevelNow <= 1;
         wr <= '{1'b1, 1'b0, 1'b1, 32'h0000_0001};
      end
      @(posedge mclk) wr <= '0;
      #1 chk("exclusiveValid", 32'h1, {31'h0, exclusiveValid});
      chk("exclusiveTc", 32'hff, {24'h0, exclusiveTc});
      @(posedge mclk) excLevelNow <= 0;
      end_sim();
   end
endmodule
bind virtual_cpu_activation_config cpu_act_cfg_props #(.P(HAS_SECOND_CFG), .C(CACHE_SHARED)) u_props (.mclk(mclk),
   .arst_n(arst_n), .wr(wr), .evt(evt), .excLevelNow(excLevelNow), .threadEnNow(threadEnNow),
   .enableVirtualCpus(enableVirtualCpus), .rdData(rdData), .cpuRun(cpuRun), .exclusiveValid(exclusiveValid),
   .masterGrant(masterGrant), .exclusiveTc(exclusiveTc));
